// ### logic/dpbr_regs.vh
// constants of the dual-port block memory: offsets, fields, sizes
// assumes inclusion by the memory top and by the bench, no other use
// How it works
// - one shared array, two independent ports
// - both ports built from one description
// - port pin polarities fixed by parameters
// - clock, enable, write, set/reset, address, data
// - read data registered on the sampling edge
// - single- or dual-port use, same shapes
// - narrow widths reach only the data storage
// - one parity bit per eight data bits
// - parity bits stored like data bits
// - write and read buses equally wide
`ifndef DPBR_REGS_VH
`define DPBR_REGS_VH

// ----------------------------------------------------------------------
// storage geometry
// ----------------------------------------------------------------------
`define DPBR_DATA_BITS     16384
`define DPBR_PAR_BITS      2048
`define DPBR_WORD_MAX      36
`define DPBR_ADDR_MAX      14
`define DPBR_CNT_W         16

// address width that a given port width needs
`define DPBR_AW(w) ((w)==1 ? 14 : (w)==2 ? 13 : (w)==4 ? 12 : \
                    (w)==9 ? 11 : (w)==18 ? 10 : 9)

// ----------------------------------------------------------------------
// register bus
// ----------------------------------------------------------------------
`define DPBR_AXI_AW        8
`define DPBR_OFF_CTRL      8'h00
`define DPBR_OFF_STATUS    8'h04
`define DPBR_CTRL_A_ON     0
`define DPBR_CTRL_B_ON     1
`define DPBR_CTRL_RST      2'h3
`define DPBR_RESP_OKAY     2'h0
`define DPBR_RESP_SLVERR   2'h2

`endif

// ### logic/dpbr_top.v
// dual-port block memory with an axi4-lite control slave
// assumes all port pins are synchronous to CLK and port clocks are slow
// enough that every level lasts at least one CLK period
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "dpbr_regs.vh"

module dpbr_top #(
   parameter          DUAL_PORT  = 1,
   parameter          A_W        = 36,
   parameter          B_W        = 36,
   parameter          A_AW       = `DPBR_AW(A_W),
   parameter          B_AW       = `DPBR_AW(B_W),
   parameter          A_CLK_RISE = 1,
   parameter          B_CLK_RISE = 1,
   parameter          A_EN_HIGH  = 1,
   parameter          B_EN_HIGH  = 1,
   parameter          A_WE_HIGH  = 1,
   parameter          B_WE_HIGH  = 1,
   parameter          A_SR_HIGH  = 1,
   parameter          B_SR_HIGH  = 1,
   parameter [35:0]   A_SRVAL    = 36'h0,
   parameter [35:0]   B_SRVAL    = 36'h0
) (
   // system
   input  wire              CLK,
   input  wire              SYS_RST,
   // port a
   input  wire              A_CLK,
   input  wire              A_EN,
   input  wire              A_WE,
   input  wire              A_SYNC_OUTPUT_SET_RESET,
   input  wire [A_AW-1:0]   A_ADDR,
   input  wire [A_W-1:0]    A_DIN,
   output wire [A_W-1:0]    A_DOUT,
   // port b
   input  wire              B_CLK,
   input  wire              B_EN,
   input  wire              B_WE,
   input  wire              B_SYNC_OUTPUT_SET_RESET,
   input  wire [B_AW-1:0]   B_ADDR,
   input  wire [B_W-1:0]    B_DIN,
   output wire [B_W-1:0]    B_DOUT,
   // axi4-lite write
   input  wire [7:0]        AWADDR,
   input  wire              AWVALID,
   output wire              AWREADY,
   input  wire [31:0]       WDATA,
   input  wire [3:0]        WSTRB,
   input  wire              WVALID,
   output wire              WREADY,
   output wire [1:0]        BRESP,
   output wire              BVALID,
   input  wire              BREADY,
   // axi4-lite read
   input  wire [7:0]        ARADDR,
   input  wire              ARVALID,
   output wire              ARREADY,
   output wire [31:0]       RDATA,
   output wire [1:0]        RRESP,
   output wire              RVALID,
   input  wire              RREADY
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // data bits of a port width; the rest of the word is parity
   function integer dbits;
      input integer w;
      begin
         dbits = (w >= 9) ? (w / 9) * 8 : w;
      end
   endfunction

   // register select: 0 control, 1 status, 3 unmapped
   function [1:0] reg_sel;
      input [7:0] addr;
      begin
         if (addr == `DPBR_OFF_CTRL)
            reg_sel = 2'h0;
         else if (addr == `DPBR_OFF_STATUS)
            reg_sel = 2'h1;
         else
            reg_sel = 2'h3;
      end
   endfunction

   // ----------------------------------------------------------------------
   // shared storage
   // ----------------------------------------------------------------------
   reg  [`DPBR_DATA_BITS-1:0] mem_data_ff;
   reg  [`DPBR_PAR_BITS-1:0]  mem_par_ff;
   reg  [1:0]                 ctrl_ff;
   wire [1:0]                 wr_all;
   wire [27:0]                addr_all;
   wire [71:0]                din_all;
   wire [31:0]                cnt_all;
   wire [14:0]                a_addr_x;
   wire [14:0]                b_addr_x;
   wire [36:0]                a_din_x;
   wire [36:0]                b_din_x;

   assign a_addr_x = {{(15-A_AW){1'b0}}, A_ADDR};
   assign b_addr_x = {{(15-B_AW){1'b0}}, B_ADDR};
   assign a_din_x  = {{(37-A_W){1'b0}}, A_DIN};
   assign b_din_x  = {{(37-B_W){1'b0}}, B_DIN};

   // ----------------------------------------------------------------------
   // ports
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : port
         localparam integer W  = (g == 0) ? A_W : B_W;
         localparam integer D  = (W >= 9) ? (W / 9) * 8 : W;
         localparam integer P  = W / 9;
         localparam integer CR = (g == 0) ? A_CLK_RISE : B_CLK_RISE;
         localparam integer EH = (g == 0) ? A_EN_HIGH : B_EN_HIGH;
         localparam integer WH = (g == 0) ? A_WE_HIGH : B_WE_HIGH;
         localparam integer SH = (g == 0) ? A_SR_HIGH : B_SR_HIGH;
         localparam [35:0]  SV = (g == 0) ? A_SRVAL : B_SRVAL;
         localparam integer ON = (g == 0) ? 1 : DUAL_PORT;

         wire        pin_clk;
         wire        pin_en;
         wire        pin_we;
         wire        pin_sr;
         wire [13:0] pin_addr;
         wire [35:0] pin_din;
         wire        edge_hit;
         wire        fire;
         reg         clk_prev_ff;
         reg  [35:0] dout_ff;
         reg  [15:0] cnt_ff;
         reg  [15:0] nxt_cnt;
         reg  [35:0] rd_word;
         integer     i;
         integer     base;

         assign pin_clk  = (g == 0) ? A_CLK : B_CLK;
         assign pin_en   = (g == 0) ? A_EN : B_EN;
         assign pin_we   = (g == 0) ? A_WE : B_WE;
         assign pin_sr   = (g == 0) ? A_SYNC_OUTPUT_SET_RESET
                                    : B_SYNC_OUTPUT_SET_RESET;
         assign pin_addr = (g == 0) ? a_addr_x[13:0] : b_addr_x[13:0];
         assign pin_din  = (g == 0) ? a_din_x[35:0] : b_din_x[35:0];

         // active edge chosen by parameter
         assign edge_hit = (CR != 0) ? (pin_clk & ~clk_prev_ff)
                                     : (~pin_clk & clk_prev_ff);
         // inputs are only looked at on the active edge
         assign fire = (ON != 0) & edge_hit & ctrl_ff[g] &
                       (pin_en == (EH != 0));
         assign wr_all[g] = fire & (pin_we == (WH != 0));
         assign addr_all[g*14 +: 14] = pin_addr;
         assign din_all[g*36 +: 36]  = pin_din;
         assign cnt_all[g*16 +: 16]  = cnt_ff;

         // word at the current address, data low and parity above it
         always @* begin
            rd_word = 36'h0;
            nxt_cnt = cnt_ff + 16'h1;
            base    = pin_addr * D;
            for (i = 0; i < 32; i = i + 1) begin
               if (i < D)
                  rd_word[i] = mem_data_ff[base + i];
            end
            base = pin_addr * P;
            for (i = 0; i < 4; i = i + 1) begin
               if (i < P)
                  rd_word[D + i] = mem_par_ff[base + i];
            end
         end

         always @(posedge CLK) begin
            if (SYS_RST) begin
               clk_prev_ff <= 1'b0;
               dout_ff     <= 36'h0;
               cnt_ff      <= 16'h0;
            end else begin
               clk_prev_ff <= pin_clk;
               if (fire) begin
                  cnt_ff <= nxt_cnt;
                  // old contents are shown on a write cycle
                  if (pin_sr == (SH != 0))
                     dout_ff <= SV;
                  else
                     dout_ff <= rd_word;
               end
            end
         end
      end
   endgenerate

   assign A_DOUT = port[0].dout_ff[A_W-1:0];
   assign B_DOUT = port[1].dout_ff[B_W-1:0];

   // ----------------------------------------------------------------------
   // array write; port a is applied last and wins a clash
   // ----------------------------------------------------------------------
   always @(posedge CLK) begin : mem_wr
      integer p;
      integer k;
      integer d;
      integer q;
      integer ad;
      for (p = 1; p >= 0; p = p - 1) begin
         d  = dbits((p == 0) ? A_W : B_W);
         q  = ((p == 0) ? A_W : B_W) / 9;
         ad = addr_all[p*14 +: 14];
         if (wr_all[p]) begin
            for (k = 0; k < 32; k = k + 1) begin
               if (k < d)
                  mem_data_ff[ad*d + k] <= din_all[p*36 + k];
            end
            // parity is stored blindly, never formed or checked here
            for (k = 0; k < 4; k = k + 1) begin
               if (k < q)
                  mem_par_ff[ad*q + k] <= din_all[p*36 + d + k];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------------
   reg        awready_ff;
   reg        wready_ff;
   reg        bvalid_ff;
   reg  [1:0] bresp_ff;
   reg  [7:0] awaddr_ff;
   reg  [31:0] wdata_ff;
   reg  [3:0] wstrb_ff;
   reg        arready_ff;
   reg        rvalid_ff;
   reg  [1:0] rresp_ff;
   reg  [31:0] rdata_ff;

   assign AWREADY = awready_ff;
   assign WREADY  = wready_ff;
   assign BVALID  = bvalid_ff;
   assign BRESP   = bresp_ff;
   assign ARREADY = arready_ff;
   assign RVALID  = rvalid_ff;
   assign RRESP   = rresp_ff;
   assign RDATA   = rdata_ff;

   always @(posedge CLK) begin
      if (SYS_RST) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `DPBR_RESP_OKAY;
         awaddr_ff  <= 8'h0;
         wdata_ff   <= 32'h0;
         wstrb_ff   <= 4'h0;
         ctrl_ff    <= `DPBR_CTRL_RST;
      end else begin
         if (AWVALID && awready_ff) begin
            awaddr_ff  <= AWADDR;
            awready_ff <= 1'b0;
         end
         if (WVALID && wready_ff) begin
            wdata_ff  <= WDATA;
            wstrb_ff  <= WSTRB;
            wready_ff <= 1'b0;
         end
         if (!awready_ff && !wready_ff && !bvalid_ff) begin
            bvalid_ff <= 1'b1;
            case (reg_sel(awaddr_ff))
               2'h0: begin
                  bresp_ff <= `DPBR_RESP_OKAY;
                  if (wstrb_ff[0])
                     ctrl_ff <= wdata_ff[1:0];
               end
               2'h1: bresp_ff <= `DPBR_RESP_OKAY;
               default: bresp_ff <= `DPBR_RESP_SLVERR;
            endcase
         end
         if (bvalid_ff && BREADY) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= `DPBR_RESP_OKAY;
         rdata_ff   <= 32'h0;
      end else begin
         if (ARVALID && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            case (reg_sel(ARADDR))
               2'h0: begin
                  rresp_ff <= `DPBR_RESP_OKAY;
                  rdata_ff <= {30'h0, ctrl_ff};
               end
               2'h1: begin
                  rresp_ff <= `DPBR_RESP_OKAY;
                  rdata_ff <= cnt_all;
               end
               default: begin
                  rresp_ff <= `DPBR_RESP_SLVERR;
                  rdata_ff <= 32'h0;
               end
            endcase
         end
         if (rvalid_ff && RREADY) begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
         end
      end
   end

endmodule // dpbr_top

// ### testbench/dpbr_top_properties.sv
// checker of the memory top: port outputs and control-bus handshakes
// assumes port a keeps default polarities and set/reset only when allowed
`timescale 1ns/1ps
module dpbr_props #(
   parameter        A_W        = 36,
   parameter        B_W        = 36,
   parameter        B_CLK_RISE = 1,
   parameter        B_EN_HIGH  = 1,
   parameter [35:0] A_SRVAL    = 36'h0,
   parameter [35:0] B_SRVAL    = 36'h0
) (
   // system
   input wire           CLK,
   input wire           SYS_RST,
   // ports
   input wire           A_CLK,
   input wire           A_EN,
   input wire           A_SYNC_OUTPUT_SET_RESET,
   input wire [A_W-1:0] A_DOUT,
   input wire           B_CLK,
   input wire           B_EN,
   input wire           B_SYNC_OUTPUT_SET_RESET,
   input wire [B_W-1:0] B_DOUT,
   // axi4-lite
   input wire           AWREADY,
   input wire           ARREADY,
   input wire           BVALID,
   input wire           BREADY,
   input wire [31:0]    RDATA,
   input wire           RVALID,
   input wire           RREADY
);
   // ------
   // port clock samples, cleared by reset as in the design
   // ------
   reg  a_prev_ff;
   reg  b_prev_ff;
   wire a_go = A_EN & A_CLK & ~a_prev_ff;
   wire b_go = (B_EN == (B_EN_HIGH != 0)) &
               ((B_CLK_RISE != 0) ? B_CLK & ~b_prev_ff : ~B_CLK & b_prev_ff);
   always @(posedge CLK) begin
      a_prev_ff <= SYS_RST ? 1'b0 : A_CLK;
      b_prev_ff <= SYS_RST ? 1'b0 : B_CLK;
   end
   // ------
   // properties
   // ------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   port_a_hold_a: assert property (!a_go |=> $stable(A_DOUT))
      else $error("port a output moved while idle");
   port_b_hold_a: assert property (!b_go |=> $stable(B_DOUT))
      else $error("port b output moved while idle");
   a_setres_a: assert property (
      a_go && A_SYNC_OUTPUT_SET_RESET |=> A_DOUT == A_SRVAL[A_W-1:0])
      else $error("port a set value wrong");
   b_setres_a: assert property (
      b_go && B_SYNC_OUTPUT_SET_RESET |=> B_DOUT == B_SRVAL[B_W-1:0])
      else $error("port b set value wrong");
   reset_out_a: assert property ($fell(SYS_RST) |-> A_DOUT == 0 &&
      B_DOUT == 0 && AWREADY && ARREADY && !BVALID && !RVALID)
      else $error("state after reset wrong");
   b_stand_a: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write response dropped");
   r_stand_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read response dropped");
   w_busy_a: assert property (BVALID |-> !AWREADY)
      else $error("write address ready while busy");
   r_busy_a: assert property (RVALID |-> !ARREADY)
      else $error("read address ready while busy");
   cover property (a_go && A_SYNC_OUTPUT_SET_RESET);
   cover property (b_go);
   cover property (RVALID && RREADY);
endmodule // dpbr_props

bind dpbr_top dpbr_props #(.A_W(A_W), .B_W(B_W), .B_CLK_RISE(B_CLK_RISE),
   .B_EN_HIGH(B_EN_HIGH), .A_SRVAL(A_SRVAL), .B_SRVAL(B_SRVAL)) props_u (
   .CLK(CLK), .SYS_RST(SYS_RST), .A_CLK(A_CLK), .A_EN(A_EN),
   .A_SYNC_OUTPUT_SET_RESET(A_SYNC_OUTPUT_SET_RESET), .A_DOUT(A_DOUT),
   .B_CLK(B_CLK), .B_EN(B_EN), .B_DOUT(B_DOUT),
   .B_SYNC_OUTPUT_SET_RESET(B_SYNC_OUTPUT_SET_RESET), .AWREADY(AWREADY),
   .ARREADY(ARREADY), .BVALID(BVALID), .BREADY(BREADY), .RDATA(RDATA),
   .RVALID(RVALID), .RREADY(RREADY));

// ### testbench/dpbr_user.sv
// user logic on one memory port: one access per call of op
// assumes op is entered just after a rising clk edge
`timescale 1ns/1ps
module dpbr_user #(
   parameter W  = 36,
   parameter AW = 9,
   parameter CR = 1,
   parameter EH = 1,
   parameter WH = 1
) (
   // system
   input  wire          clk,
   // port pins
   output reg           pclk,
   output reg           en,
   output reg           we,
   output reg           sr,
   output reg [AW-1:0]  addr,
   output reg [W-1:0]   din,
   // access over, output settled
   output reg           done
);
   // port clock parked off its active edge, enable inactive
   initial begin
      pclk <= (CR == 0);
      en   <= (EH == 0);
      we   <= 1'b0;
      sr   <= 1'b0;
      addr <= {AW{1'b0}};
      din  <= {W{1'b0}};
      done <= 1'b0;
   end
   task op(input e, input w, input s, input [AW-1:0] a, input [W-1:0] d);
      begin
         @(posedge clk);
         pclk <= (CR == 0);
         @(posedge clk);
         pclk <= (CR != 0);
         en <= e ~^ (EH != 0);
         we <= w ~^ (WH != 0);
         sr <= s;
         addr <= a;
         din <= d;
         @(posedge clk);
         done <= 1'b1;
         // released lines show the inverse of their last value, enable goes inactive
         en <= (EH == 0);
         we <= ~we;
         sr <= ~s;
         addr <= ~a;
         din <= ~d;
         @(posedge clk);
         done <= 1'b0;
      end
   endtask
endmodule // dpbr_user

// ### testbench/dual_port_block_ram_test.sv
// self-checking bench of the dual-port memory and its control slave
// assumes the port model and the checker are compiled ahead of it
`timescale 1ns/1ps
`include "dpbr_regs.vh"
module dual_port_block_ram_test;
   localparam [35:0] Z = 36'h0;
   reg         clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0;
   reg         bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   reg  [7:0]  awaddr = 8'h0, araddr = 8'h0;
   reg  [31:0] wdata = 32'h0, rs = 32'h38;
   reg  [3:0]  wstrb = 4'hf;
   reg  [1:0]  ctl = 2'h3;
   reg  [35:0] la = Z, lb = Z;
   reg         dat [0:16383];
   reg         par [0:2047];
   reg  [35:0] qa[$], qb[$], qw[$], qr[$];
   integer     errors = 0, n_checks = 0, na = 0, nb = 0, i;
   wire        ac, ae, aw, asr, adn, bc, be, bw, bsr, bdn;
   wire        awready, wready, bvalid, arready, rvalid;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [8:0]  aa, bd, bq;
   wire [10:0] ba;
   wire [35:0] ad, aq;
   initial forever #50 clk = ~clk;
   dpbr_top #(.B_W(9), .B_CLK_RISE(0), .B_EN_HIGH(0), .B_WE_HIGH(0),
      .A_SRVAL(36'h9a5a5a5a5), .B_SRVAL(36'h1c3)) dut_u (
      .CLK(clk), .SYS_RST(rst), .A_CLK(ac), .A_EN(ae), .A_WE(aw),
      .A_SYNC_OUTPUT_SET_RESET(asr), .A_ADDR(aa), .A_DIN(ad), .A_DOUT(aq),
      .B_CLK(bc), .B_EN(be), .B_WE(bw), .B_SYNC_OUTPUT_SET_RESET(bsr),
      .B_ADDR(ba), .B_DIN(bd), .B_DOUT(bq), .AWADDR(awaddr),
      .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
      .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready));
   dpbr_user ua_u (.clk(clk), .pclk(ac), .en(ae), .we(aw), .sr(asr),
      .addr(aa), .din(ad), .done(adn));
   dpbr_user #(.W(9), .AW(11), .CR(0), .EH(0), .WH(0)) ub_u (.clk(clk),
      .pclk(bc), .en(be), .we(bw), .sr(bsr), .addr(ba), .din(bd),
      .done(bdn));
   // ------
   // checking
   // ------
   task chk(input [35:0] s, input [35:0] e);
      // never-written storage reads back unknown: nothing to compare
      if (^e !== 1'bx) begin
         n_checks = n_checks + 1;
         if (s !== e) begin
            errors = errors + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
         end
      end
   endtask
   always @(posedge clk) begin
      if (adn) chk(aq, qa.pop_front());
      if (bdn) chk({27'h0, bq}, qb.pop_front());
      if (bvalid && bready) chk({34'h0, bresp}, qw.pop_front());
      if (rvalid && rready) chk({2'h0, rresp, rdata}, qr.pop_front());
   end
   task close_out;
      begin
         $display("checks %0d errors %0d", n_checks, errors);
         if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      errors = errors + 1;
      close_out;
   end
   // ------
   // stimulus tasks
   // ------
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function [35:0] par36(input [31:0] x);
      par36 = {^x[31:24], ^x[23:16], ^x[15:8], ^x[7:0], x};
   endfunction
   // p selects port b; reference is bit-level, read-first
   task automatic run(input p, input [10:0] a, input [35:0] d,
                      input e, input w, input s);
      integer k;
      integer dw;
      integer pw;
      reg [35:0] o;
      begin
         dw = p ? 8 : 32;
         pw = p ? 1 : 4;
         o = Z;
         for (k = 0; k < dw + pw; k = k + 1) begin
            o[k] = k < dw ? dat[a*dw+k] : par[a*pw+k-dw];
            if (e && w && ctl[p] && k < dw) dat[a*dw+k] = d[k];
            if (e && w && ctl[p] && k >= dw) par[a*pw+k-dw] = d[k];
         end
         if (e && ctl[p]) begin
            if (s) o = p ? 36'h1c3 : 36'h9a5a5a5a5;
            if (p) nb = nb + 1; else na = na + 1;
            if (p) lb = o; else la = o;
         end
         if (p) qb.push_back(lb); else qa.push_back(la);
         if (p) ub_u.op(e, w, s, a, d[8:0]);
         else ua_u.op(e, w, s, a[8:0], d);
      end
   endtask
   // q: response ready offered up front, else raised once valid is seen
   task wr(input [7:0] a, input [31:0] d, input [1:0] r, input [3:0] s,
           input q);
      begin
         qw.push_back({34'h0, r});
         awaddr <= a;
         wdata <= d;
         wstrb <= s;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= q;
         do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
         end while (!(bvalid && bready));
         bready <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rd(input [7:0] a, input [31:0] e, input [1:0] r, input q);
      begin
         qr.push_back({2'h0, r, e});
         araddr <= a;
         arvalid <= 1'b1;
         rready <= q;
         do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
         end while (!(rvalid && rready));
         rready <= 1'b0;
         @(posedge clk);
      end
   endtask
   // ------
   // scenarios
   // ------
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      // boundary words written twice, then read bytewise on port b
      for (i = 0; i < 4; i = i + 1) begin
         rs = lfsr(rs);
         run(1'b0, 11'(i / 2 * 511), par36(rs), 1'b1, 1'b1, 1'b0);
      end
      for (i = 0; i < 8; i = i + 1)
         run(1'b1, 11'(i / 4 * 2044 + i % 4), Z, 1'b1, 1'b0, 1'b0);
      // both ports at once, then idle enable, set/reset and refusals
      rs = lfsr(rs);
      fork
         run(1'b1, 11'h1, {27'h0, ^rs[7:0], rs[7:0]}, 1'b1, 1'b1, 1'b0);
         run(1'b0, 11'h1ff, Z, 1'b1, 1'b0, 1'b0);
      join
      run(1'b0, 11'h0, Z, 1'b1, 1'b0, 1'b0);
      run(1'b0, 11'h0, Z, 1'b0, 1'b1, 1'b0);
      run(1'b1, 11'h2, Z, 1'b0, 1'b1, 1'b0);
      run(1'b0, 11'h0, par36(rs), 1'b1, 1'b1, 1'b1);
      run(1'b1, 11'h2, {27'h0, 9'h0a5}, 1'b1, 1'b1, 1'b1);
      run(1'b0, 11'h0, Z, 1'b1, 1'b0, 1'b0);
      run(1'b1, 11'h2, Z, 1'b1, 1'b0, 1'b0);
      wr(`DPBR_OFF_CTRL, 32'h2, `DPBR_RESP_OKAY, 4'hf, 1'b0);
      ctl = 2'h2;
      run(1'b0, 11'h0, Z, 1'b1, 1'b1, 1'b0);
      wr(`DPBR_OFF_CTRL, 32'h3, `DPBR_RESP_OKAY, 4'hf, 1'b1);
      ctl = 2'h3;
      run(1'b0, 11'h0, Z, 1'b1, 1'b0, 1'b0);
      // low byte strobe clear: control must keep its value
      wr(`DPBR_OFF_CTRL, 32'h0, `DPBR_RESP_OKAY, 4'he, 1'b1);
      rd(`DPBR_OFF_CTRL, 32'h3, `DPBR_RESP_OKAY, 1'b0);
      rd(`DPBR_OFF_STATUS, {nb[15:0], na[15:0]}, `DPBR_RESP_OKAY, 1'b1);
      wr(`DPBR_OFF_STATUS, 32'h0, `DPBR_RESP_OKAY, 4'hf, 1'b1);
      wr(8'h10, 32'h0, `DPBR_RESP_SLVERR, 4'h1, 1'b0);
      rd(8'h10, 32'h0, `DPBR_RESP_SLVERR, 1'b1);
      close_out;
   end
endmodule // dual_port_block_ram_test
